// [cfg_pkg.sv]
// Constants, register map and reset values for the pattern playback configuration bank.
// Assumes a single mclk domain and a synchronous active-low reset.
// What this block does
// - Shift selector acts on the tuning word only while the RAM-source enable is set.
// - Code 0x00: RAM word in bits 23:12, twelve zero bits below.
// - Codes 1..7: keep top n old bits, RAM word next, zeros below.
// - Codes 8..11: same merge; codes 8 and 9 zero-fill four and three bits.
// - Code 0x0C: keep old bits 23:12, RAM word in bits 11:0.
// - Codes 13..16: keep top 12+k old bits, RAM bits 11 down to k below.
// - Channels 4, 3 and 2 each have a 16-bit start delay resetting to zero.
// - Channels 4 and 3 each have a 12-bit start address in bits 15:4, reset zero.
// - Channels 4 and 3 each have a 12-bit stop address in bits 15:4.
// - Channels 4 and 3 each have a 16-bit sine-cycle count resetting to one.
// - With RAM source enabled, tuning word comes from RAM at channel 1 start.
package cfg_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 16;
	localparam int TW_W = 24;
	localparam int RAM_W = 12;
	localparam int SEL_W = 5;
	localparam int NUM_REGS = 10;
	localparam int FRAME_BITS = 32;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_TW_SHIFT = 15'h0047;
	localparam logic [ADDR_W-1:0] OFF_C4_DELAY = 15'h0050;
	localparam logic [ADDR_W-1:0] OFF_C4_FIRST = 15'h0051;
	localparam logic [ADDR_W-1:0] OFF_C4_LAST = 15'h0052;
	localparam logic [ADDR_W-1:0] OFF_C4_CYCLES = 15'h0053;
	localparam logic [ADDR_W-1:0] OFF_C3_DELAY = 15'h0054;
	localparam logic [ADDR_W-1:0] OFF_C3_FIRST = 15'h0055;
	localparam logic [ADDR_W-1:0] OFF_C3_LAST = 15'h0056;
	localparam logic [ADDR_W-1:0] OFF_C3_CYCLES = 15'h0057;
	localparam logic [ADDR_W-1:0] OFF_C2_DELAY = 15'h0058;

	// ------------------------------------------------------------
	// Storage indices, in offset order
	// ------------------------------------------------------------
	localparam int IDX_TW_SHIFT = 0;
	localparam int IDX_C4_DELAY = 1;
	localparam int IDX_C4_FIRST = 2;
	localparam int IDX_C4_LAST = 3;
	localparam int IDX_C4_CYCLES = 4;
	localparam int IDX_C3_DELAY = 5;
	localparam int IDX_C3_FIRST = 6;
	localparam int IDX_C3_LAST = 7;
	localparam int IDX_C3_CYCLES = 8;
	localparam int IDX_C2_DELAY = 9;

	localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REGS] = '{
		OFF_TW_SHIFT, OFF_C4_DELAY, OFF_C4_FIRST, OFF_C4_LAST, OFF_C4_CYCLES,
		OFF_C3_DELAY, OFF_C3_FIRST, OFF_C3_LAST, OFF_C3_CYCLES, OFF_C2_DELAY};

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] RST_CYCLES = 16'h0001;
	localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{
		RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_CYCLES,
		RST_ZERO, RST_ZERO, RST_ZERO, RST_CYCLES, RST_ZERO};
	localparam logic [TW_W-1:0] RST_TW = 24'h00_0000;

	// ------------------------------------------------------------
	// Field positions and codes
	// ------------------------------------------------------------
	localparam int SEL_LSB = 0;
	localparam int ADDR_FIELD_LSB = 4;
	localparam logic [SEL_W-1:0] SEL_LAST_VALID = 5'h10;
	localparam logic [TW_W-1:0] TW_ONES = 24'hff_ffff;
	localparam logic [RAM_W-1:0] RAM_ZERO = 12'h000;

endpackage

// [cfg_serial_port.sv]
// Serial configuration slave: 16-bit instruction (read flag, 15-bit address), 16-bit data.
// Assumes sclk, cs_n and mosi are pins; sclk half period of at least five mclk periods.
module cfg_serial_port (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	output logic [cfg_pkg::ADDR_W-1:0] reg_addr,
	output logic [cfg_pkg::DATA_W-1:0] reg_wr_data,
	output logic reg_wr_en,
	output logic reg_rd_en,
	input wire logic [cfg_pkg::DATA_W-1:0] reg_rd_data
);
	import cfg_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic cs_s1_q, cs_s2_q;
	logic mosi_s1_q, mosi_s2_q;
	always_ff @(posedge mclk) begin
		sclk_s1_q <= sclk;
		sclk_s2_q <= sclk_s1_q;
		sclk_s3_q <= sclk_s2_q;
		cs_s1_q <= cs_n;
		cs_s2_q <= cs_s1_q;
		mosi_s1_q <= mosi;
		mosi_s2_q <= mosi_s1_q;
	end

	wire active = ~cs_s2_q;
	wire sclk_rise = active & sclk_s2_q & ~sclk_s3_q;
	wire sclk_fall = active & ~sclk_s2_q & sclk_s3_q;

	// ------------------------------------------------------------
	// Frame shifter
	// ------------------------------------------------------------
	logic [5:0] bit_cnt_q;
	logic [DATA_W-1:0] in_q;
	logic [DATA_W-1:0] out_q;
	logic read_q, rd_en_q, wr_en_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wr_data_q;
	wire [DATA_W-1:0] in_next = {in_q[DATA_W-2:0], mosi_s2_q};
	wire cmd_done = sclk_rise & (bit_cnt_q == 6'(DATA_W - 1));
	wire data_done = sclk_rise & (bit_cnt_q == 6'(FRAME_BITS - 1));

	always_ff @(posedge mclk) begin
		if (!rstn || !active) begin
			bit_cnt_q <= '0;
			in_q <= '0;
		end else if (sclk_rise) begin
			bit_cnt_q <= bit_cnt_q + 6'd1;
			in_q <= in_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			read_q <= 1'b0;
			addr_q <= '0;
			rd_en_q <= 1'b0;
		end else begin
			rd_en_q <= cmd_done & in_q[DATA_W-2];
			if (cmd_done) begin
				read_q <= in_q[DATA_W-2];
				addr_q <= in_next[ADDR_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wr_en_q <= 1'b0;
			wr_data_q <= '0;
		end else begin
			wr_en_q <= data_done & ~read_q;
			if (data_done)
				wr_data_q <= in_next;
		end
	end

	// Read data is loaded MSB first just after the last instruction bit rises, then shifts on later falling edges
	always_ff @(posedge mclk) begin
		if (!rstn)
			out_q <= '0;
		else if (rd_en_q)
			out_q <= reg_rd_data;
		else if (sclk_fall && bit_cnt_q > 6'(DATA_W))
			out_q <= {out_q[DATA_W-2:0], 1'b0};
	end

	assign miso = out_q[DATA_W-1];
	assign miso_oe = active & read_q & (bit_cnt_q >= 6'(DATA_W));
	assign reg_addr = addr_q;
	assign reg_wr_data = wr_data_q;
	assign reg_wr_en = wr_en_q;
	assign reg_rd_en = rd_en_q;
endmodule

// [pattern_playback_config_regs.sv]
// Pattern playback configuration bank: tuning-word merge and per-channel playback registers.
// Assumes RAM word, enable and serial tuning word come from logic on mclk.
module pattern_playback_config_regs (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic tuning_word_from_ram_en,
	input wire logic [cfg_pkg::TW_W-1:0] serial_tuning_word,
	input wire logic [cfg_pkg::RAM_W-1:0] chan1_first_addr,
	output logic [cfg_pkg::RAM_W-1:0] ram_rd_addr,
	input wire logic [cfg_pkg::RAM_W-1:0] ram_word,
	input wire logic ram_word_valid,
	output logic [cfg_pkg::TW_W-1:0] dds_tuning_word,
	output logic [cfg_pkg::SEL_W-1:0] tuning_word_shift_sel,
	output logic [cfg_pkg::DATA_W-1:0] chan4_delay_value,
	output logic [cfg_pkg::RAM_W-1:0] chan4_first_addr,
	output logic [cfg_pkg::RAM_W-1:0] chan4_last_addr,
	output logic [cfg_pkg::DATA_W-1:0] chan4_cycle_count,
	output logic [cfg_pkg::DATA_W-1:0] chan3_delay_value,
	output logic [cfg_pkg::RAM_W-1:0] chan3_first_addr,
	output logic [cfg_pkg::RAM_W-1:0] chan3_last_addr,
	output logic [cfg_pkg::DATA_W-1:0] chan3_cycle_count,
	output logic [cfg_pkg::DATA_W-1:0] chan2_delay_value
);
	import cfg_pkg::*;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic [4:0] reg_index(input logic [ADDR_W-1:0] addr);
		logic [4:0] idx;
		idx = 5'h1f;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (addr == REG_OFFSET[i])
				idx = 5'(i);
		end
		return idx;
	endfunction

	// Merge: keep top n old bits, then the RAM word, low bits past 24 fall away
	function automatic logic [TW_W-1:0] merge_tw(
		input logic [TW_W-1:0] old_tw,
		input logic [RAM_W-1:0] ram,
		input logic [SEL_W-1:0] n
	);
		logic [TW_W-1:0] keep;
		keep = ~(TW_ONES >> n);
		return (old_tw & keep) | ({ram, RAM_ZERO} >> n);
	endfunction

	// ------------------------------------------------------------
	// Serial port
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] bus_addr;
	logic [DATA_W-1:0] bus_wr_data;
	logic bus_wr_en;
	logic bus_rd_en;
	logic [DATA_W-1:0] bus_rd_data;

	cfg_serial_port u_port (
		.mclk(mclk),
		.rstn(rstn),
		.sclk(sclk),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso),
		.miso_oe(miso_oe),
		.reg_addr(bus_addr),
		.reg_wr_data(bus_wr_data),
		.reg_wr_en(bus_wr_en),
		.reg_rd_en(bus_rd_en),
		.reg_rd_data(bus_rd_data)
	);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [DATA_W-1:0] reg_q [NUM_REGS];
	wire [4:0] bus_idx = reg_index(bus_addr);
	wire bus_hit = (bus_idx != 5'h1f);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			always_ff @(posedge mclk) begin
				if (!rstn)
					reg_q[gi] <= REG_RESET[gi];
				else if (bus_wr_en && bus_hit && bus_idx == 5'(gi))
					reg_q[gi] <= bus_wr_data;
			end
		end
	endgenerate

	// Unmapped addresses read as zero, writes to them are dropped
	assign bus_rd_data = bus_hit ? reg_q[bus_idx[3:0]] : RST_ZERO;

	// ------------------------------------------------------------
	// Channel outputs
	// ------------------------------------------------------------
	assign tuning_word_shift_sel = reg_q[IDX_TW_SHIFT][SEL_LSB +: SEL_W];
	assign chan4_delay_value = reg_q[IDX_C4_DELAY];
	assign chan4_first_addr = reg_q[IDX_C4_FIRST][ADDR_FIELD_LSB +: RAM_W];
	assign chan4_last_addr = reg_q[IDX_C4_LAST][ADDR_FIELD_LSB +: RAM_W];
	assign chan4_cycle_count = reg_q[IDX_C4_CYCLES];
	assign chan3_delay_value = reg_q[IDX_C3_DELAY];
	assign chan3_first_addr = reg_q[IDX_C3_FIRST][ADDR_FIELD_LSB +: RAM_W];
	assign chan3_last_addr = reg_q[IDX_C3_LAST][ADDR_FIELD_LSB +: RAM_W];
	assign chan3_cycle_count = reg_q[IDX_C3_CYCLES];
	assign chan2_delay_value = reg_q[IDX_C2_DELAY];

	// ------------------------------------------------------------
	// Tuning word source and merge
	// ------------------------------------------------------------
	logic [TW_W-1:0] tw_q;
	logic [RAM_W-1:0] rd_addr_q;
	wire sel_valid = (tuning_word_shift_sel <= SEL_LAST_VALID);
	wire [TW_W-1:0] tw_merged = merge_tw(tw_q, ram_word, tuning_word_shift_sel);

	always_ff @(posedge mclk) begin
		if (!rstn)
			rd_addr_q <= RAM_ZERO;
		else
			rd_addr_q <= chan1_first_addr;
	end

	always_ff @(posedge mclk) begin
		if (!rstn)
			tw_q <= RST_TW;
		else if (!tuning_word_from_ram_en)
			tw_q <= serial_tuning_word;
		else if (ram_word_valid && sel_valid)
			tw_q <= tw_merged;
	end
	// Reserved selector codes leave the tuning word as it stands

	assign ram_rd_addr = rd_addr_q;
	assign dds_tuning_word = tw_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic ev_q;
	logic [TW_W-1:0] old_q;
	logic [RAM_W-1:0] ram_q;
	logic [SEL_W-1:0] sel_q;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ev_q <= 1'b0;
			old_q <= RST_TW;
			ram_q <= RAM_ZERO;
			sel_q <= '0;
		end else begin
			ev_q <= tuning_word_from_ram_en & ram_word_valid;
			old_q <= tw_q;
			ram_q <= ram_word;
			sel_q <= tuning_word_shift_sel;
		end
	end
	wire [4:0] k_q = sel_q - 5'd12;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	property p_serial_source;
		!tuning_word_from_ram_en |=> dds_tuning_word == $past(serial_tuning_word);
	endproperty
	a_serial_source: assert property (p_serial_source)
		else $error("tuning word not taken from serial word while RAM source off");

	property p_code0;
		ev_q && sel_q == 5'h00 |-> dds_tuning_word == {ram_q, RAM_ZERO};
	endproperty
	a_code0: assert property (p_code0)
		else $error("code 0 merge wrong");

	property p_code1_7;
		ev_q && sel_q inside {[5'h01:5'h07]} |->
			dds_tuning_word[5'd23 - sel_q -: RAM_W] == ram_q &&
			24'(dds_tuning_word << (5'd12 + sel_q)) == RST_TW &&
			(dds_tuning_word >> (5'd24 - sel_q)) == (old_q >> (5'd24 - sel_q));
	endproperty
	a_code1_7: assert property (p_code1_7)
		else $error("codes 1 to 7 merge wrong");

	property p_code8_11;
		ev_q && sel_q inside {[5'h08:5'h0b]} |->
			dds_tuning_word[5'd23 - sel_q -: RAM_W] == ram_q &&
			24'(dds_tuning_word << (5'd12 + sel_q)) == RST_TW &&
			(dds_tuning_word >> (5'd24 - sel_q)) == (old_q >> (5'd24 - sel_q));
	endproperty
	a_code8_11: assert property (p_code8_11)
		else $error("codes 8 to 11 merge wrong");

	property p_code8_fill;
		ev_q && sel_q == 5'h08 |-> dds_tuning_word[3:0] == 4'h0 &&
			dds_tuning_word[15:4] == ram_q && dds_tuning_word[23:16] == old_q[23:16];
	endproperty
	a_code8_fill: assert property (p_code8_fill)
		else $error("code 8 zero fill not four bits");

	property p_code12;
		ev_q && sel_q == 5'h0c |-> dds_tuning_word == {old_q[23:12], ram_q};
	endproperty
	a_code12: assert property (p_code12)
		else $error("code 12 merge wrong");

	property p_code13_16;
		ev_q && sel_q inside {[5'h0d:5'h10]} |->
			(dds_tuning_word & (TW_ONES >> sel_q)) == 24'({RAM_ZERO, ram_q} >> k_q) &&
			(dds_tuning_word >> (5'd24 - sel_q)) == (old_q >> (5'd24 - sel_q));
	endproperty
	a_code13_16: assert property (p_code13_16)
		else $error("codes 13 to 16 merge wrong");

	property p_reserved_hold;
		ev_q && sel_q > SEL_LAST_VALID |-> dds_tuning_word == old_q;
	endproperty
	a_reserved_hold: assert property (p_reserved_hold)
		else $error("reserved code changed tuning word");

	property p_delay_write;
		bus_wr_en && bus_addr == OFF_C4_DELAY |=> chan4_delay_value == $past(bus_wr_data);
	endproperty
	a_delay_write: assert property (p_delay_write)
		else $error("channel 4 delay not written");

	property p_first_field;
		bus_wr_en && bus_addr == OFF_C3_FIRST |=>
			chan3_first_addr == $past(bus_wr_data[15:4]) ##1 chan3_first_addr == $past(chan3_first_addr);
	endproperty
	a_first_field: assert property (p_first_field)
		else $error("channel 3 start address field wrong");

	property p_last_field;
		bus_wr_en && bus_addr == OFF_C4_LAST |=> chan4_last_addr == $past(bus_wr_data[15:4]);
	endproperty
	a_last_field: assert property (p_last_field)
		else $error("channel 4 stop address field wrong");

	property p_cycles_reset;
		!$past(rstn) |-> chan4_cycle_count == RST_CYCLES && chan3_cycle_count == RST_CYCLES;
	endproperty
	a_cycles_reset: assert property (p_cycles_reset)
		else $error("cycle count not one after reset");

	property p_ram_hold;
		tuning_word_from_ram_en && !ram_word_valid |=> dds_tuning_word == $past(dds_tuning_word);
	endproperty
	a_ram_hold: assert property (p_ram_hold)
		else $error("tuning word moved without RAM word");

	property p_rd_addr;
		##1 ram_rd_addr == $past(chan1_first_addr);
	endproperty
	a_rd_addr: assert property (p_rd_addr)
		else $error("RAM read address not channel 1 start");

	c_merge_mid: cover property (ev_q && sel_q == 5'h0c);
	c_merge_top: cover property (ev_q && sel_q == SEL_LAST_VALID);
	c_reg_write: cover property (bus_wr_en && bus_hit);
	c_reg_read: cover property (bus_rd_en && bus_hit ##[1:200] miso_oe);
endmodule

// [cfg_host.sv]
// Host model that drives the serial configuration port: mode 0, MSB first, 32-bit frames.
// Assumes mclk runs at 20 MHz; each sclk phase lasts six mclk periods.
module cfg_host (
	input wire logic mclk,
	input wire logic miso,
	output logic sclk,
	output logic cs_n,
	output logic mosi
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// ------------------------------------------------------------
	// One frame: read flag, 15-bit address, 16-bit data
	// ------------------------------------------------------------
	task automatic xfer(input logic rd, input logic [14:0] addr, input logic [15:0] wdata,
			output logic [15:0] rdata);
		logic [31:0] frame;
		frame = {rd, addr, wdata};
		rdata = 16'h0000;
		@(negedge mclk);
		cs_n = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			mosi = frame[i];
			repeat (6) @(negedge mclk);
			sclk = 1'b1;
			if (i < 16) rdata[i] = miso;
			repeat (6) @(negedge mclk);
			sclk = 1'b0;
		end
		// Let the last bit land before select goes away, then keep the idle gap
		repeat (6) @(negedge mclk);
		cs_n = 1'b1;
		mosi = ~mosi;
		repeat (6) @(negedge mclk);
	endtask
endmodule

// [tb_pattern_playback_config_regs.sv]
// Self-checking bench for the pattern playback configuration bank.
// Assumes the host model drives the serial pins; bench drives the tuning-word inputs.
module tb_pattern_playback_config_regs;
	timeunit 1ns;
	timeprecision 100ps;
	import cfg_pkg::*;

	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe;
	logic en = 1'b0;
	logic [TW_W-1:0] stw = 24'h00_0000;
	logic [RAM_W-1:0] c1_addr = 12'h000;
	logic [RAM_W-1:0] ram_rd_addr;
	logic [RAM_W-1:0] ram = 12'h000;
	logic ram_valid = 1'b0;
	logic [TW_W-1:0] tw;
	logic [SEL_W-1:0] sel;
	logic [DATA_W-1:0] c4_dly, c4_cyc, c3_dly, c3_cyc, c2_dly;
	logic [RAM_W-1:0] c4_first, c4_last, c3_first, c3_last;
	int n_errors = 0;
	int num_checks = 0;

	always #25 mclk = ~mclk;

	cfg_host i_cfg_host (.mclk(mclk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

	pattern_playback_config_regs i_pattern_playback_config_regs (
		.mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.miso_oe(miso_oe), .tuning_word_from_ram_en(en), .serial_tuning_word(stw),
		.chan1_first_addr(c1_addr), .ram_rd_addr(ram_rd_addr), .ram_word(ram),
		.ram_word_valid(ram_valid), .dds_tuning_word(tw), .tuning_word_shift_sel(sel),
		.chan4_delay_value(c4_dly), .chan4_first_addr(c4_first), .chan4_last_addr(c4_last),
		.chan4_cycle_count(c4_cyc), .chan3_delay_value(c3_dly), .chan3_first_addr(c3_first),
		.chan3_last_addr(c3_last), .chan3_cycle_count(c3_cyc), .chan2_delay_value(c2_dly));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [14:0] a, input logic [15:0] v);
		logic [15:0] unused;
		i_cfg_host.xfer(1'b0, a, v, unused);
	endtask

	task automatic rd(input logic [14:0] a, output logic [15:0] v);
		i_cfg_host.xfer(1'b1, a, 16'h0000, v);
	endtask

	function automatic logic [15:0] pat(input int i);
		return {4'(i + 1), 12'h6B5};
	endfunction

	// Bit by bit: top n old bits, then the RAM word, then zeros
	function automatic logic [23:0] merged(input logic [23:0] old, input logic [11:0] r,
			input int n);
		logic [23:0] t;
		t = 24'h00_0000;
		if (n > 16) return old;
		for (int b = 0; b < 24; b++) begin
			if (23 - b < n) t[b] = old[b];
			else if (23 - b < n + 12) t[b] = r[b + n - 12];
		end
		return t;
	endfunction

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		logic [15:0] d;
		check(c4_cyc, 24'h00_0001);
		check(c3_cyc, 24'h00_0001);
		check(tw, 24'h00_0000);
		for (int i = 0; i < NUM_REGS; i++) begin
			rd(REG_OFFSET[i], d);
			check(d, REG_RESET[i]);
		end
		check(miso_oe, 24'h00_0000);
		// Output enable must stand high in the data phase of a read frame
		fork
			rd(OFF_C4_CYCLES, d);
			begin
				repeat (251) @(negedge mclk);
				check(miso_oe, 24'h00_0001);
			end
		join
		check(d, RST_CYCLES);
	endtask

	task automatic test_regs();
		logic [15:0] d;
		for (int i = 0; i < NUM_REGS; i++) wr(REG_OFFSET[i], pat(i));
		for (int i = 0; i < NUM_REGS; i++) begin
			rd(REG_OFFSET[i], d);
			check(d, pat(i));
		end
		check(sel, pat(IDX_TW_SHIFT) & 16'h001f);
		check(c4_dly, pat(IDX_C4_DELAY));
		check(c4_first, pat(IDX_C4_FIRST) >> 4);
		check(c4_last, pat(IDX_C4_LAST) >> 4);
		check(c4_cyc, pat(IDX_C4_CYCLES));
		check(c3_dly, pat(IDX_C3_DELAY));
		check(c3_first, pat(IDX_C3_FIRST) >> 4);
		check(c3_last, pat(IDX_C3_LAST) >> 4);
		check(c3_cyc, pat(IDX_C3_CYCLES));
		check(c2_dly, pat(IDX_C2_DELAY));
		// Unmapped and aliased places neither store nor disturb mapped ones
		// Output enable stays low through a write frame
		fork
			wr(15'h0048, 16'hBEEF);
			begin
				repeat (251) @(negedge mclk);
				check(miso_oe, 24'h00_0000);
			end
		join
		wr(15'h4050, 16'hBEEF);
		rd(15'h0048, d);
		check(d, 24'h00_0000);
		rd(15'h4050, d);
		check(d, 24'h00_0000);
		check(c4_dly, pat(IDX_C4_DELAY));
	endtask

	task automatic test_merge();
		logic [23:0] exp;
		for (int c = 0; c <= 17; c++) begin
			wr(OFF_TW_SHIFT, 16'hA5A0 | 16'(c));
			check(sel, 24'(c));
			en = 1'b0;
			stw = 24'h96_3C5A;
			@(negedge mclk);
			check(tw, 24'h96_3C5A);
			en = 1'b1;
			ram_valid = 1'b1;
			ram = 12'hB7E;
			stw = 24'h12_3456;
			@(negedge mclk);
			ram_valid = 1'b0;
			exp = merged(24'h96_3C5A, 12'hB7E, c);
			check(tw, exp);
			@(negedge mclk);
			check(tw, exp);
		end
	endtask

	task automatic test_source();
		en = 1'b0;
		ram_valid = 1'b1;
		ram = 12'h3C1;
		stw = 24'h5E_A17C;
		c1_addr = 12'h9D3;
		@(negedge mclk);
		check(tw, 24'h5E_A17C);
		check(ram_rd_addr, 24'h00_09D3);
		c1_addr = 12'h26B;
		#1;
		check(ram_rd_addr, 24'h00_09D3);
		@(negedge mclk);
		check(ram_rd_addr, 24'h00_026B);
		ram_valid = 1'b0;
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
		test_reset();
		test_regs();
		test_merge();
		test_source();
		complete_run();
	end

	initial begin
		repeat (100000) @(posedge mclk);
		n_errors++;
		complete_run();
	end
endmodule
